// ==== core/tsrg_pkg.sv ====
// Purpose: Shared constants and types for the tape speed reference generator.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes: Crystal is sampled on pclk, so the crystal must stay well under pclk/2.
package tsrg_pkg;

  // Register byte offsets
  localparam logic [11:0] TSRG_OFF_CTRL = 12'h000;
  localparam logic [11:0] TSRG_OFF_STATUS = 12'h004;
  localparam logic [11:0] TSRG_OFF_DIVIDER = 12'h008;

  // Control register fields
  localparam int TSRG_CTRL_BIAS_LSB = 0;
  localparam int TSRG_CTRL_BIAS_W = 2;

  // Status register fields
  localparam int TSRG_ST_SPEED_LSB = 0;
  localparam int TSRG_ST_CMD_SLOW = 9;
  localparam int TSRG_ST_REC_MODE = 10;
  localparam int TSRG_ST_FAULT = 11;
  localparam int TSRG_ST_REC_REF = 12;
  localparam int TSRG_ST_CAP_REF = 13;
  localparam int TSRG_ST_BIAS_REF = 14;

  // Divider register fields
  localparam int TSRG_DIV_BIN_LSB = 0;
  localparam int TSRG_DIV_DEC_LSB = 8;

  // Divider chain figures
  localparam int TSRG_SPEEDS = 9;
  localparam int TSRG_BIN_STAGES = 8;
  localparam int TSRG_DECADE = 10;
  localparam int TSRG_DEC_W = 3;

  // Bias source strap codes
  typedef enum logic [1:0] {
    TSRG_BIAS_8M = 2'b00,
    TSRG_BIAS_16M = 2'b01,
    TSRG_BIAS_4M = 2'b10,
    TSRG_BIAS_2M = 2'b11
  } tsrg_bias_sel_t;

  localparam tsrg_bias_sel_t TSRG_CTRL_RESET = TSRG_BIAS_8M;

  // Pin inputs travelling together; speed bit 0 is 240 ips, bit 8 is 15/16 ips
  typedef struct packed {
    logic [TSRG_SPEEDS-1:0] speed_sel;
    logic cmd_slowest;
    logic record_mode;
  } tsrg_pins_t;

  localparam int TSRG_PINS_W = TSRG_SPEEDS + 2;

  // Reference outputs travelling together
  typedef struct packed {
    logic bias_ref;
    logic record_ref;
    logic capstan_ref;
  } tsrg_refs_t;

endpackage

// ==== core/tsrg_top.sv ====
// Purpose: Tape speed reference generator with bias, record and capstan outputs.
// Assumes: Crystal and control pins are asynchronous to pclk and synchronised here.
// Notes: Divider stages advance on edges of the sampled crystal.
//
// What this block does
// R1 - The crystal is halved to 8 MHz and halved again to two separate 4 MHz taps.
// R2 - One 4 MHz tap is halved once more to give a 2 MHz bias option.
// R3 - Bias source is 8 MHz by default, or 16, 4 or 2 MHz by a static setting.
// R4 - The 4 MHz tap is divided by ten symmetrically into a 400 kHz square wave.
// R5 - The 400 kHz wave is the 240 ips record reference and clocks the binary chain.
// R6 - An 8-stage binary chain held in one 8-bit counter gives 200 kHz from its first stage.
// R7 - Each stage halves the previous one, ending near 1.562 kHz for 15/16 ips.
// R8 - Only the tap of the selected speed reaches the record reference output.
// R9 - Speeds 240 down to 15/16 ips map to 400 kHz down to 1562 Hz in halving steps.
// R10 - Except with the 15/16 ips command the capstan reference is the record reference halved.
// R11 - With the 15/16 ips command the capstan output takes the undivided record reference.
// R12 - The bias output carries the chosen bias only while record mode is asserted.
// R13 - The speed switching unit asserts exactly one of the nine speed lines.
// R14 - With no speed line or several asserted, record and capstan outputs stay low.
`timescale 1ns/1ns
module tsrg_top #(
  parameter int BIN_STAGES = tsrg_pkg::TSRG_BIN_STAGES,
  parameter int DECADE = tsrg_pkg::TSRG_DECADE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_clk,
  input wire tsrg_pkg::tsrg_pins_t pins,
  output tsrg_pkg::tsrg_refs_t refs
);

  localparam int NTAPS = tsrg_pkg::TSRG_SPEEDS;
  localparam int DW = tsrg_pkg::TSRG_DEC_W;
  localparam logic [DW-1:0] DEC_LAST = DW'(DECADE / 2 - 1);

  // Elaboration checks
  if (BIN_STAGES != NTAPS - 1) begin : g_bad_stages
    $error("BIN_STAGES must be one less than the number of speed lines");
  end
  if (DECADE < 2 || DECADE % 2 != 0 || DECADE / 2 > (1 << DW)) begin : g_bad_decade
    $error("DECADE must be even and fit the decade counter");
  end

  // Exactly one line asserted
  function automatic logic one_hot(input logic [NTAPS-1:0] v);
    logic seen;
    logic bad;
    seen = 1'b0;
    bad = 1'b0;
    for (int i = 0; i < NTAPS; i++) begin
      if (v[i]) begin
        bad = bad | seen;
        seen = 1'b1;
      end
    end
    return seen & ~bad;
  endfunction

  // Register decode, shared by read and write paths
  function automatic logic [1:0] reg_index(input logic [11:0] a);
    if (a == tsrg_pkg::TSRG_OFF_CTRL) begin
      return 2'h1;
    end else if (a == tsrg_pkg::TSRG_OFF_STATUS) begin
      return 2'h2;
    end else if (a == tsrg_pkg::TSRG_OFF_DIVIDER) begin
      return 2'h3;
    end else begin
      return 2'h0;
    end
  endfunction

  // Pin synchronisers
  logic xtal_meta;
  logic xtal_sync;
  logic xtal_prev;
  logic [tsrg_pkg::TSRG_PINS_W-1:0] pins_meta;
  tsrg_pkg::tsrg_pins_t pins_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_meta <= crystal_clk;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins;
      pins_sync <= pins_meta;
    end
  end

  // Divider chain state
  logic div_8m;
  logic div_4m_a;
  logic div_4m_b;
  logic bias_extra_halver;
  logic [DW-1:0] decade_count;
  logic decade_divider;
  logic [BIN_STAGES-1:0] bin_count;

  logic tick_16m;
  logic tick_8m;
  logic tick_4m;
  logic tick_400k;

  // Rising edge of the crystal, then falling edges of each later stage
  assign tick_16m = xtal_sync & ~xtal_prev;
  assign tick_8m = tick_16m & div_8m;
  assign tick_4m = tick_8m & div_4m_a;
  assign tick_400k = tick_4m & (decade_count == DEC_LAST) & decade_divider;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_8m <= 1'b0;
    end else if (tick_16m) begin
      div_8m <= ~div_8m; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_4m_a <= 1'b0;
      div_4m_b <= 1'b0;
    end else if (tick_8m) begin
      div_4m_a <= ~div_4m_a; // R1
      div_4m_b <= ~div_4m_b; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_extra_halver <= 1'b0;
    end else if (tick_8m && div_4m_b) begin
      bias_extra_halver <= ~bias_extra_halver; // R2
    end
  end

  // Symmetrical divide by ten: toggle every half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decade_count <= '0;
      decade_divider <= 1'b0;
    end else if (tick_4m) begin
      if (decade_count == DEC_LAST) begin
        decade_count <= '0;
        decade_divider <= ~decade_divider; // R4
      end else begin
        decade_count <= decade_count + DW'(1); // R4
      end
    end
  end

  // Binary chain clocked by the 400 kHz wave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_count <= '0;
    end else if (tick_400k) begin
      bin_count <= bin_count + BIN_STAGES'(1); // R5 R6 R7
    end
  end

  // Speed taps, fastest first
  logic [NTAPS-1:0] taps;
  assign taps[0] = decade_divider; // R5 R9

  for (genvar i = 1; i < NTAPS; i++) begin : g_taps
    assign taps[i] = bin_count[i-1]; // R6 R7 R9
  end

  // Record reference selection
  logic sel_valid;
  logic next_record_ref;
  assign sel_valid = one_hot(pins_sync.speed_sel); // R14
  assign next_record_ref = sel_valid & |(taps & pins_sync.speed_sel); // R8 R14

  // Capstan path
  logic capstan_halving_toggle;
  logic next_capstan_ref;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capstan_halving_toggle <= 1'b0;
    end else if (!sel_valid) begin
      capstan_halving_toggle <= 1'b0; // R14
    end else if (refs.record_ref && !next_record_ref) begin
      capstan_halving_toggle <= ~capstan_halving_toggle; // R10
    end
  end

  always_comb begin
    if (!sel_valid) begin
      next_capstan_ref = 1'b0; // R14
    end else if (pins_sync.cmd_slowest) begin
      next_capstan_ref = next_record_ref; // R11
    end else begin
      next_capstan_ref = capstan_halving_toggle; // R10
    end
  end

  // Bias source
  tsrg_pkg::tsrg_bias_sel_t bias_source_strap;
  logic bias_src;
  logic next_bias_ref;

  always_comb begin
    case (bias_source_strap)
      tsrg_pkg::TSRG_BIAS_16M: bias_src = xtal_sync; // R3
      tsrg_pkg::TSRG_BIAS_4M: bias_src = div_4m_a; // R3
      tsrg_pkg::TSRG_BIAS_2M: bias_src = bias_extra_halver; // R3
      default: bias_src = div_8m; // R3
    endcase
  end

  assign next_bias_ref = pins_sync.record_mode & bias_src; // R12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refs <= '0;
    end else begin
      refs.bias_ref <= next_bias_ref; // R12
      refs.record_ref <= next_record_ref; // R8
      refs.capstan_ref <= next_capstan_ref; // R10 R11
    end
  end

  // APB slave: one wait state, answer registered
  logic access;
  logic [1:0] idx;
  assign access = psel & penable & ~pready;
  assign idx = reg_index(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_source_strap <= tsrg_pkg::TSRG_CTRL_RESET;
    end else if (psel && penable && pready && pwrite && idx == 2'h1) begin
      bias_source_strap <= tsrg_pkg::tsrg_bias_sel_t'(
        pwdata[tsrg_pkg::TSRG_CTRL_BIAS_LSB +: tsrg_pkg::TSRG_CTRL_BIAS_W]); // R3
    end
  end

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = '0;
    if (idx == 2'h1) begin
      next_prdata[tsrg_pkg::TSRG_CTRL_BIAS_LSB +: tsrg_pkg::TSRG_CTRL_BIAS_W] =
        bias_source_strap;
    end else if (idx == 2'h2) begin
      next_prdata[tsrg_pkg::TSRG_ST_SPEED_LSB +: NTAPS] = pins_sync.speed_sel;
      next_prdata[tsrg_pkg::TSRG_ST_CMD_SLOW] = pins_sync.cmd_slowest;
      next_prdata[tsrg_pkg::TSRG_ST_REC_MODE] = pins_sync.record_mode;
      next_prdata[tsrg_pkg::TSRG_ST_FAULT] = ~sel_valid;
      next_prdata[tsrg_pkg::TSRG_ST_REC_REF] = refs.record_ref;
      next_prdata[tsrg_pkg::TSRG_ST_CAP_REF] = refs.capstan_ref;
      next_prdata[tsrg_pkg::TSRG_ST_BIAS_REF] = refs.bias_ref;
    end else if (idx == 2'h3) begin
      next_prdata[tsrg_pkg::TSRG_DIV_BIN_LSB +: BIN_STAGES] = bin_count;
      next_prdata[tsrg_pkg::TSRG_DIV_DEC_LSB +: DW] = decade_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (access) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= (idx == 2'h0) | (pwrite & (idx != 2'h1));
    end else begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ==== verif/tsrg_far_model.sv ====
// Purpose: Far side model, phase comparator and bias amplifier inputs.
// Assumes: Receives refs only; measures each reference in pclk cycles.
// Notes: Index 2 bias, 1 record, 0 capstan.
`timescale 1ns/1ns
module tsrg_far_model (
  input wire logic pclk,
  input wire tsrg_pkg::tsrg_refs_t refs,
  output int per[3],
  output int hi[3],
  output int rises[3]
);
  logic [2:0] last;
  int cnt[3];
  int hcnt[3];
  always_ff @(posedge pclk) begin
    last <= refs;
    for (int i = 0; i < 3; i++) begin
      if (refs[i] && !last[i]) begin
        per[i] <= cnt[i] + 1;
        cnt[i] <= 0;
        rises[i] <= rises[i] + 1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
      hcnt[i] <= refs[i] ? hcnt[i] + 1 : 0;
      if (!refs[i] && last[i]) begin
        hi[i] <= hcnt[i];
      end
    end
  end
endmodule

// ==== verif/tsrg_chk_sva.sv ====
// Purpose: Port checker for the reference generator.
// Assumes: One clock domain, pclk.
// Notes: Bound to every tsrg_top instance.
`timescale 1ns/1ns
module tsrg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tsrg_pkg::tsrg_pins_t pins,
  input wire tsrg_pkg::tsrg_refs_t refs
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready held");
  one_wait_a:
    assert property (psel && penable && !pready |=> pready) else $error("no answer");
  err_ready_a:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  rdata_idle_a:
    assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  sel_fault_a:
    assert property ((!$onehot(pins.speed_sel))[*6] |-> !refs.record_ref && !refs.capstan_ref)
    else $error("refs active on bad select");
  bias_gate_a:
    assert property ((!pins.record_mode)[*6] |-> !refs.bias_ref) else $error("bias leak");
  cap_halve_a:
    assert property ((!pins.cmd_slowest && $onehot(pins.speed_sel))[*8]
      ##0 $changed(refs.capstan_ref) |-> !refs.record_ref) else $error("capstan toggle");
  slow_follow_a:
    assert property ((pins.cmd_slowest && $onehot(pins.speed_sel))[*8]
      ##0 $rose(refs.capstan_ref) |-> ##[0:1] refs.record_ref) else $error("capstan follow");
endmodule
bind tsrg_top tsrg_chk i_tsrg_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
  .refs(refs));

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the reference generator.
// Assumes: Crystal period 60 ns, three pclk cycles, so 400 kHz tap is 120 cycles.
// Notes: Speeds 240 to 7 1/2 ips measured in full; slower taps read back over APB.
`timescale 1ns/1ns
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic crystal_clk;
  tsrg_pkg::tsrg_pins_t pins = '{speed_sel: 9'h001, cmd_slowest: 1'b0, record_mode: 1'b1};
  tsrg_pkg::tsrg_refs_t refs;
  int per[3];
  int hi[3];
  int rises[3];
  int bad_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic er;
  always #10 pclk = ~pclk;
  initial begin
    crystal_clk = 1'b0;
    #5;
    forever #30 crystal_clk = ~crystal_clk;
  end
  tsrg_top i_tsrg_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_clk(crystal_clk), .pins(pins), .refs(refs));
  tsrg_far_model i_tsrg_far_model(.pclk(pclk), .refs(refs), .per(per), .hi(hi),
    .rises(rises));
  task automatic close_out();
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      $display("BAD %0t apb timeout", $time);
      close_out();
    end
  endtask
  task automatic wait_rise(input int i, input int n, input int lim);
    int s;
    int c;
    s = rises[i];
    c = 0;
    while (rises[i] - s < n && c < lim) begin
      @(posedge pclk);
      c++;
    end
    if (c >= lim) begin
      bad_count++;
      $display("BAD %0t edge timeout", $time);
      close_out();
    end
  endtask
  task automatic t_regs();
    apb(1'b0, tsrg_pkg::TSRG_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, tsrg_pkg::TSRG_OFF_CTRL, 32'h3);
    apb(1'b0, tsrg_pkg::TSRG_OFF_CTRL, 32'h0);
    chk(rd, 32'h3, "ctrl readback");
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(er), 32'h1, "unmapped err");
    apb(1'b1, tsrg_pkg::TSRG_OFF_STATUS, 32'hffff);
    chk(32'(er), 32'h1, "status write err");
    apb(1'b0, tsrg_pkg::TSRG_OFF_STATUS, 32'h0);
    chk(32'(rd[11:0]), 32'h401, "status");
    $display("done regs");
  endtask
  task automatic t_bias();
    int exp[4] = '{6, 3, 12, 24};
    int s;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, tsrg_pkg::TSRG_OFF_CTRL, 32'(c));
      wait_rise(2, 3, 300);
      chk(per[2], exp[c], "bias period");
    end
    @(posedge pclk);
    pins.record_mode <= 1'b0;
    repeat (10) @(posedge pclk);
    s = rises[2];
    repeat (100) @(posedge pclk);
    chk(rises[2] - s, 0, "bias gated");
    pins.record_mode <= 1'b1;
    $display("done bias");
  endtask
  task automatic t_speed();
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk);
      pins.speed_sel <= 9'(1 << k);
      wait_rise(0, 3, 1000 << k);
      chk(per[1], 120 << k, "record period");
      chk(per[0], 240 << k, "capstan period");
      if (k == 0) chk(hi[1], 60, "decade duty");
    end
    $display("done speed");
  endtask
  task automatic t_low();
    logic [31:0] d0;
    logic [31:0] st;
    int tries;
    for (int k = 6; k < 9; k++) begin
      @(posedge pclk);
      pins.speed_sel <= 9'(1 << k);
      pins.cmd_slowest <= (k == 8);
      repeat (10) @(posedge pclk);
      tries = 0;
      do begin
        apb(1'b0, tsrg_pkg::TSRG_OFF_DIVIDER, 32'h0);
        d0 = rd;
        apb(1'b0, tsrg_pkg::TSRG_OFF_STATUS, 32'h0);
        st = rd;
        apb(1'b0, tsrg_pkg::TSRG_OFF_DIVIDER, 32'h0);
        tries++;
      end while (rd[7:0] !== d0[7:0] && tries < 4);
      if (rd[7:0] !== d0[7:0]) begin
        bad_count++;
        $display("BAD %0t divider unsettled", $time);
        close_out();
      end
      chk(32'(st[tsrg_pkg::TSRG_ST_REC_REF]), 32'(d0[k-1]), "slow tap");
      if (k == 8) chk(32'(st[tsrg_pkg::TSRG_ST_CAP_REF]), 32'(d0[7]), "slow capstan");
    end
    pins.cmd_slowest <= 1'b0;
    $display("done low");
  endtask
  task automatic t_slow();
    @(posedge pclk);
    pins.speed_sel <= 9'h002;
    pins.cmd_slowest <= 1'b1;
    wait_rise(0, 3, 2000);
    chk(per[0], 240, "capstan undivided");
    pins.cmd_slowest <= 1'b0;
    $display("done slow");
  endtask
  task automatic t_fault();
    logic [8:0] v[2] = '{9'h000, 9'h003};
    int s;
    for (int j = 0; j < 2; j++) begin
      @(posedge pclk);
      pins.speed_sel <= v[j];
      repeat (10) @(posedge pclk);
      s = rises[1] + rises[0];
      repeat (300) @(posedge pclk);
      chk(rises[1] + rises[0] - s, 0, "refs quiet");
      apb(1'b0, tsrg_pkg::TSRG_OFF_STATUS, 32'h0);
      chk(32'(rd[tsrg_pkg::TSRG_ST_FAULT]), 32'h1, "fault flag");
    end
    pins.speed_sel <= 9'h001;
    $display("done fault");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bias();
    t_speed();
    t_low();
    t_slow();
    t_fault();
    close_out();
  end
endmodule
